//--- verilog/comm_decode_core.sv
// instruction decode, sequencing and register addressing of the core
// assumes host and line unit logic run on clk; control store loaded
// through the loader port while the sequencer is held in reset
`timescale 1ns/10ps
`default_nettype none
module comm_decode_core
    import comm_decode_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csLoadEn,
    input wire logic [9:0] csLoadAddr,
    input wire logic [15:0] csLoadData,
    input wire logic hostWrEn,
    input wire logic [1:0] hostWordAddr,
    input wire logic [1:0] hostByteEn,
    input wire logic [15:0] hostWrData,
    output logic [15:0] hostRdData,
    input wire logic oneSecTick,
    input wire logic missingMemory,
    input wire logic xferInDone,
    input wire logic xferOutDone,
    input wire logic irqTaken,
    output logic [7:0] xferControl,
    output logic [7:0] miscControl,
    output logic [63:0] plainWriteGroup,
    output logic [2:0] lineRdAddr,
    output logic lineRdStrobe,
    input wire logic [7:0] lineRdData,
    output logic [2:0] lineWrAddr,
    output logic [7:0] lineWrData,
    output logic lineWrStrobe,
    output logic [9:0] programCounter
);
    typedef struct packed {
        logic [9:0] pc;
        logic [7:0] ptr;
        logic [7:0] hold;
        logic [7:0] buffered_alu_result;
        logic carry;
        logic zero;
        logic [7:0] xfer;
        logic [7:0] misc;
        logic [MP_BYTES-1:0][7:0] mp;
        logic [15:0] hostRd;
        logic [2:0] luAddr;
        logic [7:0] luData;
        logic luWr;
    } state_t;

    state_t s_q;
    state_t s_d;

    // memories held apart from the state record; no reset needed on them
    logic [15:0] controlStore [CS_DEPTH];
    logic [7:0] dataRam [DATA_RAM_DEPTH];
    logic [7:0] scratchpadFile [SCRATCH_DEPTH];

    function automatic logic isBranch(input logic [2:0] opc);
        return opc[2] & (opc != OP_MOV_HOLD);
    endfunction

    // ****************************************
    // decode
    // ****************************************
    logic [15:0] instr;
    logic [2:0] opc;
    logic [2:0] sel;
    logic [1:0] ptrFn;
    logic [3:0] lowAddr;
    logic branchOp;
    logic outDest;
    logic [7:0] aluA;
    logic [7:0] aluB;
    logic [3:0] aluFn;
    logic [7:0] aluRes;
    logic aluCarry;
    logic condOk;
    logic [7:0] plainRd;
    logic [7:0] starRd;
    logic memWe;
    logic scrWe;

    assign instr = controlStore[s_q.pc];
    assign opc = instr[OPC_LSB+:3];
    assign sel = instr[SEL_LSB+:3];
    assign ptrFn = instr[PAGE_LSB+:2];
    assign lowAddr = instr[3:0];
    assign branchOp = isBranch(opc);
    assign outDest = !branchOp && (sel == DST_PLAIN || sel == DST_STAR);

    // group read muxes: plain 0-7 transfer bytes, 8-15 line unit
    always_comb begin
        plainRd = lowAddr[3] ? lineRdData : s_q.mp[PLAIN_BASE + 32'(lowAddr[2:0])];
        starRd = 8'h00;
        if (!lowAddr[3]) begin
            starRd = s_q.mp[STAR_BASE + 32'(lowAddr[2:0])];
        end else if (lowAddr == ADDR_XFER_CTRL) begin
            starRd = s_q.xfer;
        end else if (lowAddr == ADDR_MISC) begin
            starRd = s_q.misc;
        end
    end

    // operand selection; immediate move bypasses the function field
    always_comb begin
        aluA = scratchpadFile[outDest ? 4'h0 : lowAddr];
        aluFn = instr[FN_LSB+:4];
        unique case (opc)
            OP_MOV_IMM: begin
                aluB = instr[7:0];
                aluFn = FN_PASS_B;
            end
            OP_MOV_PLAIN: aluB = plainRd;
            OP_MOV_STAR: aluB = starRd;
            OP_MOV_MEM, OP_BR_MEM: aluB = dataRam[s_q.ptr];
            OP_MOV_HOLD, OP_BR_HOLD: aluB = s_q.hold;
            OP_BR_IMM: aluB = instr[7:0];
        endcase
    end

    alu_function_unit aluUnit (
        .operandA(aluA),
        .operandB(aluB),
        .carryIn(s_q.carry),
        .fnSel(aluFn),
        .highOpcode(instr[OPC_HIGH_BIT]),
        .result(aluRes),
        .carryOut(aluCarry)
    );

    // branch test on flags left by the last move
    always_comb begin
        unique case (sel)
            CND_ALWAYS: condOk = 1'b1;
            CND_CARRY: condOk = s_q.carry;
            CND_ZERO: condOk = s_q.zero;
            default: condOk = s_q.hold[sel - CND_HOLD_BASE];
        endcase
    end

    assign lineRdAddr = lowAddr[2:0];
    assign lineRdStrobe = !branchOp && opc == OP_MOV_PLAIN && lowAddr[3];
    assign memWe = !branchOp && sel == DST_MEM;
    assign scrWe = !branchOp && (sel == DST_SCR || sel == DST_SCR_HOLD);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.luWr = 1'b0;
        s_d.pc = s_q.pc + 10'h001;
        // hardware completion clears the go bits
        if (xferInDone) s_d.xfer[XFER_IN_GO] = 1'b0;
        if (xferOutDone) s_d.xfer[XFER_OUT_GO] = 1'b0;
        if (irqTaken) s_d.misc[MISC_IRQ] = 1'b0;
        // host bytes land first, so a same cycle core write overrides
        if (hostWrEn) begin
            if (hostByteEn[0]) s_d.mp[STAR_BASE + 32'({hostWordAddr, 1'b0})] = hostWrData[7:0];
            if (hostByteEn[1]) s_d.mp[STAR_BASE + 32'({hostWordAddr, 1'b1})] = hostWrData[15:8];
        end
        s_d.hostRd = {s_q.mp[STAR_BASE + 32'({hostWordAddr, 1'b1})],
                      s_q.mp[STAR_BASE + 32'({hostWordAddr, 1'b0})]};
        if (branchOp) begin
            if (condOk) begin
                s_d.pc = {instr[PAGE_LSB+:2], (opc == OP_BR_IMM) ? instr[7:0] : aluRes};
            end
        end else begin
            s_d.carry = aluCarry;
            s_d.zero = (aluRes == 8'h00);
            s_d.buffered_alu_result = aluRes;
            unique case (ptrFn)
                PTR_INC: s_d.ptr = s_q.ptr + 8'h01;
                PTR_LOAD: s_d.ptr = s_q.buffered_alu_result;
                default: s_d.ptr = s_q.ptr;
            endcase
            unique case (sel)
                DST_PLAIN: begin
                    if (lowAddr[3]) begin
                        s_d.luWr = 1'b1;
                        s_d.luAddr = lowAddr[2:0];
                        s_d.luData = aluRes;
                    end else begin
                        s_d.mp[PLAIN_BASE + 32'(lowAddr[2:0])] = aluRes;
                    end
                end
                DST_STAR: begin
                    if (!lowAddr[3]) s_d.mp[STAR_BASE + 32'(lowAddr[2:0])] = aluRes;
                    if (lowAddr == ADDR_XFER_CTRL) s_d.xfer = aluRes;
                    if (lowAddr == ADDR_MISC) s_d.misc = aluRes;
                end
                DST_HOLD, DST_SCR_HOLD: s_d.hold = aluRes;
                DST_HOLD_SHR: s_d.hold = {1'b0, aluRes[7:1]};
                default: s_d.hold = s_q.hold;
            endcase
        end
        // events set last so that they win over a clearing write
        if (oneSecTick) s_d.misc[MISC_TICK] = 1'b1;
        if (missingMemory) s_d.misc[MISC_MISSING] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.pc <= PC_RESET;
            s_q.xfer <= XFER_CTRL_RESET;
            s_q.misc <= MISC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // memory writes; control store only from the loader, never the core
    always_ff @(posedge clk) begin
        if (csLoadEn) controlStore[csLoadAddr] <= csLoadData;
        if (memWe) dataRam[s_q.ptr] <= aluRes;
        if (scrWe) scratchpadFile[lowAddr] <= aluRes;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hostRdData = s_q.hostRd;
    assign xferControl = s_q.xfer;
    assign miscControl = s_q.misc;
    assign plainWriteGroup = s_q.mp[PLAIN_BASE+:8];
    assign lineWrAddr = s_q.luAddr;
    assign lineWrData = s_q.luData;
    assign lineWrStrobe = s_q.luWr;
    assign programCounter = s_q.pc;

    // ****************************************
    // checks
    // ****************************************
    a_branch_imm_target: assert property (@(posedge clk) disable iff (!rst_b)
        (opc == OP_BR_IMM && condOk) |=> s_q.pc == $past({instr[12:11], instr[7:0]}))
        else $error("immediate branch missed its target");
    a_branch_fall_through: assert property (@(posedge clk) disable iff (!rst_b)
        (branchOp && !condOk) |=> s_q.pc == $past(s_q.pc) + 10'h001)
        else $error("untaken branch did not step");
    a_alu_branch_target: assert property (@(posedge clk) disable iff (!rst_b)
        (branchOp && opc != OP_BR_IMM && condOk) |=> s_q.pc[7:0] == $past(aluRes))
        else $error("computed branch low byte wrong");
    a_move_steps_pc: assert property (@(posedge clk) disable iff (!rst_b)
        !branchOp |=> s_q.pc == $past(s_q.pc) + 10'h001)
        else $error("move did not advance pc");
    a_pointer_increment: assert property (@(posedge clk) disable iff (!rst_b)
        (!branchOp && ptrFn == PTR_INC) |=> s_q.ptr == $past(s_q.ptr) + 8'h01)
        else $error("pointer increment lost");
    a_pointer_load: assert property (@(posedge clk) disable iff (!rst_b)
        (!branchOp && ptrFn == PTR_LOAD) |=> s_q.ptr == $past(s_q.buffered_alu_result))
        else $error("pointer load wrong");
    a_zero_flag_move: assert property (@(posedge clk) disable iff (!rst_b)
        !branchOp |=> s_q.zero == ($past(aluRes) == 8'h00))
        else $error("zero flag not from move result");
    a_flags_hold_branch: assert property (@(posedge clk) disable iff (!rst_b)
        branchOp |=> $stable(s_q.carry) && $stable(s_q.zero))
        else $error("branch disturbed flags");
    a_holding_shift: assert property (@(posedge clk) disable iff (!rst_b)
        (!branchOp && sel == DST_HOLD_SHR) |=> s_q.hold == {1'b0, $past(aluRes[7:1])})
        else $error("shifted holding value wrong");
    a_line_write: assert property (@(posedge clk) disable iff (!rst_b)
        (!branchOp && sel == DST_PLAIN && lowAddr[3]) |=> lineWrStrobe
            && lineWrAddr == $past(lowAddr[2:0]) && lineWrData == $past(aluRes))
        else $error("line unit write strobe wrong");
    a_tick_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        oneSecTick |=> miscControl[MISC_TICK])
        else $error("tick event lost");
    a_missing_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        missingMemory |=> miscControl[MISC_MISSING])
        else $error("missing memory event lost");
endmodule
`default_nettype wire

//--- shared/comm_decode_pkg.sv
// constants shared by the microcontroller decode core and its alu
// assumes a single 100 MHz clock and an active low asynchronous reset
package comm_decode_pkg;
    // ****************************************
    // store sizes
    // ****************************************
    localparam int CS_DEPTH = 1024;
    localparam int DATA_RAM_DEPTH = 256;
    localparam int SCRATCH_DEPTH = 16;
    localparam int MP_BYTES = 16;
    localparam int STAR_BASE = 0;
    localparam int PLAIN_BASE = 8;
    // ****************************************
    // instruction fields
    // ****************************************
    localparam int OPC_LSB = 13;
    localparam int PAGE_LSB = 11;
    localparam int SEL_LSB = 8;
    localparam int FN_LSB = 4;
    localparam int OPC_HIGH_BIT = 14;
    localparam logic [2:0] OP_MOV_IMM = 3'h0;
    localparam logic [2:0] OP_MOV_PLAIN = 3'h1;
    localparam logic [2:0] OP_MOV_STAR = 3'h2;
    localparam logic [2:0] OP_MOV_MEM = 3'h3;
    localparam logic [2:0] OP_BR_IMM = 3'h4;
    localparam logic [2:0] OP_MOV_HOLD = 3'h5;
    localparam logic [2:0] OP_BR_MEM = 3'h6;
    localparam logic [2:0] OP_BR_HOLD = 3'h7;
    // pointer function, bits 12:11 of a move
    localparam logic [1:0] PTR_KEEP = 2'h0;
    localparam logic [1:0] PTR_INC = 2'h1;
    localparam logic [1:0] PTR_LOAD = 2'h2;
    // destinations, bits 10:8 of a move
    localparam logic [2:0] DST_NONE = 3'h0;
    localparam logic [2:0] DST_PLAIN = 3'h1;
    localparam logic [2:0] DST_STAR = 3'h2;
    localparam logic [2:0] DST_SCR = 3'h3;
    localparam logic [2:0] DST_SCR_HOLD = 3'h4;
    localparam logic [2:0] DST_HOLD = 3'h5;
    localparam logic [2:0] DST_MEM = 3'h6;
    localparam logic [2:0] DST_HOLD_SHR = 3'h7;
    // branch conditions, bits 10:8 of a branch
    localparam logic [2:0] CND_ALWAYS = 3'h0;
    localparam logic [2:0] CND_CARRY = 3'h1;
    localparam logic [2:0] CND_ZERO = 3'h2;
    localparam logic [2:0] CND_HOLD_BASE = 3'h3;
    // alu function used by an immediate move
    localparam logic [3:0] FN_PASS_B = 4'h5;
    // ****************************************
    // star group control registers
    // ****************************************
    localparam logic [3:0] ADDR_XFER_CTRL = 4'h8;
    localparam logic [3:0] ADDR_MISC = 4'h9;
    localparam int XFER_IN_GO = 0;
    localparam int XFER_OUT_GO = 1;
    localparam int XFER_IN_ADDR_LSB = 2;
    localparam int MISC_TICK = 0;
    localparam int MISC_MISSING = 1;
    localparam int MISC_IRQ = 2;
    localparam int MISC_VECTOR = 3;
    localparam int MISC_OUT_ADDR_LSB = 4;
    localparam logic [7:0] XFER_CTRL_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [9:0] PC_RESET = 10'h000;
endpackage

//--- verilog/alu_function_unit.sv
// eight bit alu steered by a function lookup rom
// assumes operands are settled within the same clock as the caller
`timescale 1ns/10ps
`default_nettype none
module alu_function_unit
    import comm_decode_pkg::*;
(
    input wire logic [7:0] operandA,
    input wire logic [7:0] operandB,
    input wire logic carryIn,
    input wire logic [3:0] fnSel,
    input wire logic highOpcode,
    output logic [7:0] result,
    output logic carryOut
);
    // ****************************************
    // function rom
    // ****************************************
    // word is {use carry, op}; opcodes with bit 14 set (star and memory moves, memory and holding branches) never fold in the stored carry
    function automatic logic [4:0] fromWord(input logic [4:0] addr);
        logic useCarry;
        useCarry = (addr[3:0] == 4'h1 || addr[3:0] == 4'h3) && !addr[4];
        return {useCarry, addr[3:0]};
    endfunction

    logic [4:0] ctlWord;
    logic [8:0] wide;
    logic cin;

    // ****************************************
    // datapath
    // ****************************************
    always_comb begin
        ctlWord = fromWord({highOpcode, fnSel});
        cin = ctlWord[4] & carryIn;
        wide = 9'h000;
        unique case (ctlWord[3:0])
            4'h0, 4'h1: wide = {1'b0, operandA} + {1'b0, operandB} + {8'h00, cin};
            4'h2, 4'h3: wide = {1'b0, operandA} - {1'b0, operandB} - {8'h00, cin};
            4'h4: wide = {1'b0, operandA};
            4'h5: wide = {1'b0, operandB};
            4'h6: wide = {1'b0, operandA & operandB};
            4'h7: wide = {1'b0, operandA | operandB};
            4'h8: wide = {1'b0, operandA ^ operandB};
            4'h9: wide = {1'b0, ~operandB};
            4'hA: wide = {1'b0, operandA} + 9'h001;
            4'hB: wide = {1'b0, operandB} + 9'h001;
            4'hC: wide = {1'b0, operandA} - 9'h001;
            4'hD: wide = {1'b0, operandB} - 9'h001;
            4'hE: wide = {1'b0, operandA & ~operandB};
            4'hF: wide = 9'h000;
        endcase
        result = wide[7:0];
        carryOut = wide[8];
    end
endmodule
`default_nettype wire

//--- verif/line_unit_model.sv
// behavioural model of the synchronous line unit behind the parallel port
// assumes the core drives strobes and addresses from the rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module line_unit_model #(
    parameter logic [7:0] SWITCH_TWO = 8'hA5,
    parameter logic [7:0] BOOT_OFFSET = 8'h3C
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] lineRdAddr,
    input wire logic lineRdStrobe,
    output logic [7:0] lineRdData,
    input wire logic [2:0] lineWrAddr,
    input wire logic [7:0] lineWrData,
    input wire logic lineWrStrobe,
    output logic [7:0] wrCount,
    output logic [2:0] lastWrAddr,
    output logic [7:0] lastWrData,
    output logic [7:0] popCount
);
    // ****************************************
    // line unit registers
    // ****************************************
    logic [7:0] regs [8];
    logic [7:0] rxFifo [4];
    logic [7:0] lastRd;

    // unselected port shows the inverse of the last byte, never a stale copy
    always_comb begin
        if (!lineRdStrobe) begin
            lineRdData = ~lastRd;
        end else if (lineRdAddr == 3'h0) begin
            lineRdData = rxFifo[popCount[1:0]];
        end else begin
            lineRdData = regs[lineRdAddr];
        end
    end

    // fifo pops and writes land on the edge that samples the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrCount <= 8'h00;
            popCount <= 8'h00;
            lastRd <= 8'h00;
            lastWrAddr <= 3'h0;
            lastWrData <= 8'h00;
            rxFifo <= '{8'h5A, 8'hC3, 8'h96, 8'h0F};
            regs <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, SWITCH_TWO, BOOT_OFFSET, 8'h00};
        end else begin
            if (lineRdStrobe) begin
                lastRd <= lineRdData;
                if (lineRdAddr == 3'h0) begin
                    popCount <= popCount + 8'h01;
                end
            end
            if (lineWrStrobe) begin
                wrCount <= wrCount + 8'h01;
                lastWrAddr <= lineWrAddr;
                lastWrData <= lineWrData;
                // switch packs (5 and 6) and address 0 are read only; writes there are not stored
                if (lineWrAddr != 3'h0 && lineWrAddr != 3'h5 && lineWrAddr != 3'h6) begin
                    regs[lineWrAddr] <= lineWrData;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the decode core with a line unit model attached
// assumes the control store is loaded while the core is held in reset
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import comm_decode_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic csLoadEn = 1'b0;
    logic [9:0] csLoadAddr = 10'h000;
    logic [15:0] csLoadData = 16'h0000;
    logic hostWrEn = 1'b0;
    logic [1:0] hostWordAddr = 2'h0;
    logic [1:0] hostByteEn = 2'h0;
    logic [15:0] hostWrData = 16'h0000;
    logic [4:0] evt = 5'h00;
    logic [7:0] lineRdData, xferControl, miscControl, lineWrData, wrCount, lastWrData, popCount;
    logic [15:0] hostRdData;
    logic [63:0] plainWriteGroup;
    logic [2:0] lineRdAddr, lineWrAddr, lastWrAddr;
    logic lineRdStrobe, lineWrStrobe;
    logic [9:0] programCounter;
    int nFail = 0;
    int nCompared = 0;

    // free running 100 MHz clock
    always #5 clk = ~clk;

    comm_decode_core i_dut (.clk(clk), .rst_b(rst_b), .csLoadEn(csLoadEn),
        .csLoadAddr(csLoadAddr), .csLoadData(csLoadData), .hostWrEn(hostWrEn),
        .hostWordAddr(hostWordAddr), .hostByteEn(hostByteEn), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .oneSecTick(evt[0]), .missingMemory(evt[1]),
        .xferInDone(evt[2]), .xferOutDone(evt[3]), .irqTaken(evt[4]),
        .xferControl(xferControl), .miscControl(miscControl),
        .plainWriteGroup(plainWriteGroup), .lineRdAddr(lineRdAddr),
        .lineRdStrobe(lineRdStrobe), .lineRdData(lineRdData), .lineWrAddr(lineWrAddr),
        .lineWrData(lineWrData), .lineWrStrobe(lineWrStrobe),
        .programCounter(programCounter));

    line_unit_model i_line (.clk(clk), .rst_b(rst_b), .lineRdAddr(lineRdAddr),
        .lineRdStrobe(lineRdStrobe), .lineRdData(lineRdData), .lineWrAddr(lineWrAddr),
        .lineWrData(lineWrData), .lineWrStrobe(lineWrStrobe), .wrCount(wrCount),
        .lastWrAddr(lastWrAddr), .lastWrData(lastWrData), .popCount(popCount));

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [15:0] mk(input logic [2:0] op, input logic [1:0] ptr,
        input logic [2:0] sel, input logic [7:0] low);
        return {op, ptr, sel, low};
    endfunction

    task automatic final_report();
        $display("compared %0d mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    // bounded wait; a stuck or misrouted sequencer ends the run here
    task automatic wait_pc(input logic [9:0] target);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (programCounter === target) begin
                return;
            end
        end
        nFail++;
        $display("BAD t=%0t seen=%0h expected=%0h", $time, programCounter, target);
        final_report();
    endtask

    // loader holds its enable across back to back words
    task automatic cs(input logic [9:0] a, input logic [15:0] w);
        @(posedge clk);
        csLoadEn <= 1'b1;
        csLoadAddr <= a;
        csLoadData <= w;
    endtask

    task automatic host_write(input logic [1:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge clk);
        hostWrEn <= 1'b1;
        hostWordAddr <= a;
        hostByteEn <= be;
        hostWrData <= d;
        @(posedge clk);
        hostWrEn <= 1'b0;
    endtask

    task automatic host_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        hostWordAddr <= a;
        @(posedge clk);
        @(posedge clk);
        #1;
        d = hostRdData;
    endtask

    task automatic pulse(input int idx, input logic [7:0] expX, input logic [7:0] expM);
        @(posedge clk);
        evt[idx] <= 1'b1;
        @(posedge clk);
        evt[idx] <= 1'b0;
        #1;
        check(xferControl, expX);
        check(miscControl, expM);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // word 0 parks the core on itself so the first release runs no unknown code
    task automatic t_reset();
        cs(10'h000, mk(OP_BR_IMM, 2'h0, CND_ALWAYS, 8'h00));
        repeat (5) @(posedge clk);
        #1;
        check(programCounter, PC_RESET);
        check(xferControl, XFER_CTRL_RESET);
        check(miscControl, MISC_RESET);
        check(plainWriteGroup, 64'h0);
        check(hostRdData, 16'h0000);
        @(posedge clk);
        csLoadEn <= 1'b0;
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(programCounter, 10'h000);
        $display("test reset done");
    endtask

    // second reset in mid-run, program loaded while held
    task automatic t_load();
        @(posedge clk);
        rst_b <= 1'b0;
        cs(10'h000, mk(OP_MOV_IMM, PTR_KEEP, DST_STAR, 8'h52));
        cs(10'h001, mk(OP_MOV_IMM, PTR_KEEP, DST_PLAIN, 8'hA9));
        cs(10'h002, mk(OP_MOV_IMM, PTR_KEEP, DST_PLAIN, 8'h03));
        cs(10'h003, mk(OP_BR_IMM, 2'h2, CND_ALWAYS, 8'h10));
        cs(10'h210, mk(OP_BR_IMM, 2'h3, CND_ZERO, 8'h00));
        cs(10'h211, mk(OP_MOV_IMM, PTR_KEEP, DST_NONE, 8'h00));
        cs(10'h212, mk(OP_BR_IMM, 2'h3, CND_ZERO, 8'h00));
        cs(10'h300, mk(OP_MOV_IMM, PTR_KEEP, DST_HOLD, 8'h0F));
        cs(10'h301, mk(OP_MOV_HOLD, PTR_KEEP, DST_STAR, {FN_PASS_B, ADDR_XFER_CTRL}));
        cs(10'h302, mk(OP_MOV_IMM, PTR_KEEP, DST_HOLD, 8'h2C));
        cs(10'h303, mk(OP_MOV_HOLD, PTR_KEEP, DST_STAR, {FN_PASS_B, ADDR_MISC}));
        cs(10'h304, mk(OP_MOV_PLAIN, PTR_KEEP, DST_HOLD, {FN_PASS_B, 4'h8}));
        cs(10'h305, mk(OP_MOV_HOLD, PTR_KEEP, DST_STAR, {FN_PASS_B, 4'h4}));
        cs(10'h306, mk(OP_MOV_IMM, PTR_KEEP, DST_SCR, 8'h70));
        cs(10'h307, mk(OP_MOV_HOLD, PTR_KEEP, DST_PLAIN, 8'h4A));
        cs(10'h308, mk(OP_BR_HOLD, 2'h3, CND_ALWAYS, {FN_PASS_B, 4'h0}));
        cs(10'h35A, mk(OP_MOV_IMM, PTR_KEEP, DST_NONE, 8'h40));
        cs(10'h35B, mk(OP_MOV_IMM, PTR_LOAD, DST_HOLD_SHR, 8'h81));
        cs(10'h35C, mk(OP_MOV_IMM, PTR_KEEP, DST_MEM, 8'h25));
        cs(10'h35D, mk(OP_BR_MEM, 2'h1, CND_ALWAYS, 8'h00));
        cs(10'h195, mk(OP_MOV_MEM, PTR_INC, DST_PLAIN, {FN_PASS_B, 4'h6}));
        cs(10'h196, mk(OP_MOV_HOLD, PTR_KEEP, DST_STAR, {FN_PASS_B, 4'h5}));
        cs(10'h197, mk(OP_BR_IMM, 2'h1, CND_ALWAYS, 8'h97));
        #1;
        check(programCounter, PC_RESET);
        @(posedge clk);
        csLoadEn <= 1'b0;
        rst_b <= 1'b1;
        $display("test load done");
    endtask

    task automatic t_program();
        wait_pc(10'h003);
        check(lastWrAddr, 3'h1);
        check(lastWrData, 8'hA9);
        check(plainWriteGroup[31:24], 8'h03);
        wait_pc(10'h211);
        wait_pc(10'h300);
        wait_pc(10'h306);
        check(xferControl, 8'h0F);
        check(miscControl, 8'h2C);
        check(popCount, 8'h01);
        wait_pc(10'h35A);
        check(wrCount, 8'h02);
        check(lastWrAddr, 3'h2);
        check(lastWrData, 8'h70);
        // memory branch: scratch 0 (70) plus data ram at loaded pointer (25)
        wait_pc(10'h195);
        wait_pc(10'h197);
        check(plainWriteGroup[55:48], 8'h25);
        @(posedge clk);
        #1;
        check(programCounter, 10'h197);
        $display("test program done");
    endtask

    // event inputs against the bits that microcode set
    task automatic t_events();
        pulse(2, 8'h0E, 8'h2C);
        pulse(3, 8'h0C, 8'h2C);
        pulse(4, 8'h0C, 8'h28);
        pulse(0, 8'h0C, 8'h29);
        pulse(1, 8'h0C, 8'h2B);
        $display("test events done");
    endtask

    task automatic t_host();
        logic [15:0] d;
        host_read(2'h1, d);
        check(d[7:0], 8'h52);
        host_read(2'h2, d);
        check(d[7:0], 8'h5A);
        check(d[15:8], 8'h40);
        host_write(2'h3, 2'h3, 16'hBEEF);
        host_read(2'h3, d);
        check(d, 16'hBEEF);
        host_write(2'h3, 2'h2, 16'h1234);
        host_read(2'h3, d);
        check(d, 16'h12EF);
        $display("test host done");
    endtask

    // main sequence
    initial begin
        t_reset();
        repeat (2) @(posedge clk);
        t_load();
        t_program();
        t_events();
        t_host();
        final_report();
    end
endmodule
`default_nettype wire
